// >>> sbu_defines.vh
// Register offsets, field positions, reset values and timing counts of the serial bus unit
`ifndef SBU_DEFINES_VH
`define SBU_DEFINES_VH
`define SBU_IDX_MODE 20'hf0231
`define SBU_IDX_LOW 20'hf0232
`define SBU_IDX_HIGH 20'hf0233
`define SBU_IDX_MAIN 20'hf0230
`define SBU_IDX_LINE 20'hf0234
`define SBU_ADDR_MODE 12'h0c4
`define SBU_ADDR_LOW 12'h0c8
`define SBU_ADDR_HIGH 12'h0cc
`define SBU_ADDR_MAIN 12'h0c0
`define SBU_ADDR_LINE 12'h0d0
`define SBU_MODE_RESET 8'h00
`define SBU_WIDTH_RESET 8'hff
`define SBU_MAIN_RESET 8'h00
`define SBU_BIT_WAKE 7
`define SBU_BIT_CLK_LVL 5
`define SBU_BIT_DAT_LVL 4
`define SBU_BIT_SPEED 3
`define SBU_BIT_FILTER 2
`define SBU_BIT_ENABLE 7
`define SBU_FILTER_LEN 4
`endif

// >>> sbu_line_filter.v
// Digital noise filter for one sampled bus line
`timescale 1ns/1ps
`default_nettype none
`include "sbu_defines.vh"
module sbu_line_filter (
   input wire pclk,
   input wire presetn,
   input wire line_in,
   input wire filter_on,
   output reg line_out
);
   reg [`SBU_FILTER_LEN-1:0] hist;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist <= {`SBU_FILTER_LEN{1'b1}};
         line_out <= 1'b1;
      end else begin
         hist <= {hist[`SBU_FILTER_LEN-2:0], line_in};
         // Only a level stable across the whole history passes when filtering
         if (!filter_on) begin
            line_out <= line_in; // [R13]
         end else if (&{hist, line_in}) begin
            line_out <= 1'b1; // [R13]
         end else if (~|{hist, line_in}) begin
            line_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sbu_mode_ctrl.v
// APB register block with mode, wake, line sense and serial clock width logic
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sbu_defines.vh"
// Requirements on this block and its use
// R1: Software changes mode fields except wakeup only while interface disabled.
// R2: Mode control register resets to zero.
// R3: Mode register layout: wake 7, clock 5, data 4, speed 3, filter 2.
// R4: Wakeup bit enables address-match wakeup during stop mode.
// R5: Software waits three clocks after setting wakeup before stop.
// R6: Software clears wakeup after a match before resuming traffic.
// R7: Match interrupt timing same with wakeup set, within one sample.
// R8: Stop-condition interrupt suppressed while wakeup bit is set.
// R9: Software sets wakeup only when all participation flags are clear.
// R10: Clock-line level bit follows the pin when enabled, else zero.
// R11: Data-line level bit follows the pin when enabled, else zero.
// R12: Speed select chooses standard mode at 0, fast mode at 1.
// R13: Filter bit applies a digital noise filter to bus inputs.
// R14: Filter setting never alters the generated transfer clock; the filter here delays scl_filtered and so the start of the high count.
// R15: Peripheral clock at least 1 MHz standard, 3.5 MHz fast.
// R16: Low-width register, 8 bits, resets to all ones.
// R17: Data hold time is a quarter of the programmed low period.
// R18: High-width register, 8 bits, resets to all ones.
// R19: Software routes the pins through port setup registers.
// R20: Lines are open-drain outputs read through sampled inputs.
// R21: Low and high periods count peripheral clock cycles.
// R22: Open-drain line drives low only; released bus reads high.
module sbu_mode_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire serial_clock_pin_in,
   output wire serial_clock_pin_out,
   output wire serial_clock_pin_oe,
   input wire serial_data_pin_in,
   output wire serial_data_pin_out,
   output wire serial_data_pin_oe,
   input wire clock_drive_req,
   input wire data_drive_low,
   input wire stop_seen,
   input wire stop_irq_enable,
   input wire match_seen,
   input wire in_stop_mode,
   output reg stop_irq,
   output reg match_irq,
   output reg wake_request,
   output wire fast_mode,
   output reg data_out_strobe,
   output wire scl_filtered,
   output wire sda_filtered
);
   reg [7:0] main_bus_control;
   reg match_wakeup_bit;
   reg speed_select;
   reg noise_filter_on;
   reg [7:0] clock_low_width;
   reg [7:0] clock_high_width;
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg clock_line_level;
   reg data_line_level;
   reg [8:0] phase_cnt;
   reg clk_low_phase;
   reg clk_drive_low;
   reg [31:0] read_data;
   reg [7:0] next_read;
   wire interface_enable;
   wire wr_en;
   wire rd_en;
   wire addr_ok;
   wire [7:0] wbyte;
   wire [8:0] low_count;
   wire [8:0] high_count;
   wire [8:0] hold_count;

   assign interface_enable = main_bus_control[`SBU_BIT_ENABLE];
   assign wbyte = pwdata[7:0];
   assign addr_ok = (paddr == `SBU_ADDR_MODE) || (paddr == `SBU_ADDR_LOW) ||
                    (paddr == `SBU_ADDR_HIGH) || (paddr == `SBU_ADDR_MAIN) ||
                    (paddr == `SBU_ADDR_LINE);
   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign rd_en = psel & ~penable & ~pwrite;
   assign prdata = read_data;

   // Registers; widths and mode fields are not gated by enable, software must honour that
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_bus_control <= `SBU_MAIN_RESET;
         match_wakeup_bit <= 1'b0; // [R2]
         speed_select <= 1'b0;
         noise_filter_on <= 1'b0;
         clock_low_width <= `SBU_WIDTH_RESET; // [R16]
         clock_high_width <= `SBU_WIDTH_RESET; // [R18]
      end else if (wr_en) begin
         case (paddr)
            `SBU_ADDR_MAIN: main_bus_control <= wbyte;
            `SBU_ADDR_MODE: begin
               match_wakeup_bit <= wbyte[`SBU_BIT_WAKE]; // [R3]
               speed_select <= wbyte[`SBU_BIT_SPEED]; // [R12]
               noise_filter_on <= wbyte[`SBU_BIT_FILTER];
            end
            `SBU_ADDR_LOW: clock_low_width <= wbyte;
            `SBU_ADDR_HIGH: clock_high_width <= wbyte;
            default: main_bus_control <= main_bus_control;
         endcase
      end
   end

   always @* begin
      next_read = 8'h00;
      case (paddr)
         `SBU_ADDR_MAIN: next_read = main_bus_control;
         // Bits 6, 1 and 0 read zero
         `SBU_ADDR_MODE: next_read = {match_wakeup_bit, 1'b0, clock_line_level,
                                      data_line_level, speed_select, noise_filter_on,
                                      2'b00}; // [R3]
         `SBU_ADDR_LOW: next_read = clock_low_width;
         `SBU_ADDR_HIGH: next_read = clock_high_width;
         `SBU_ADDR_LINE: next_read = {6'h00, clk_drive_low, clk_low_phase};
         default: next_read = 8'h00;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_data <= 32'h0000_0000;
      end else if (rd_en) begin
         read_data <= {24'h000000, next_read};
      end
   end

   // Two-stage pin synchronisers; second stage feeds everything else
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
      end else begin
         scl_sync <= {scl_sync[0], serial_clock_pin_in}; // [R20]
         sda_sync <= {sda_sync[0], serial_data_pin_in};
      end
   end

   sbu_line_filter u_scl_filter (
      .pclk(pclk),
      .presetn(presetn),
      .line_in(scl_sync[1]),
      .filter_on(noise_filter_on),
      .line_out(scl_filtered)
   );

   sbu_line_filter u_sda_filter (
      .pclk(pclk),
      .presetn(presetn),
      .line_in(sda_sync[1]),
      .filter_on(noise_filter_on),
      .line_out(sda_filtered)
   );

   // Level bits show the raw synchronised pin, forced low when disabled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_line_level <= 1'b0;
         data_line_level <= 1'b0;
      end else begin
         clock_line_level <= interface_enable & scl_sync[1]; // [R10]
         data_line_level <= interface_enable & sda_sync[1]; // [R11]
      end
   end

   assign fast_mode = speed_select; // [R12]

   // Period counts come from widths only; filter setting has no path here
   assign low_count = {1'b0, clock_low_width}; // [R21] [R14]
   assign high_count = {1'b0, clock_high_width}; // [R21]
   assign hold_count = {3'b000, clock_low_width[7:2]}; // [R17]

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_cnt <= 9'h000;
         clk_low_phase <= 1'b0;
         clk_drive_low <= 1'b0;
         data_out_strobe <= 1'b0;
      end else begin
         data_out_strobe <= 1'b0;
         if (!interface_enable || !clock_drive_req) begin
            phase_cnt <= 9'h000;
            clk_low_phase <= 1'b0;
            clk_drive_low <= 1'b0;
         end else if (clk_low_phase) begin
            clk_drive_low <= 1'b1;
            if (phase_cnt == hold_count) begin
               data_out_strobe <= 1'b1; // [R17]
            end
            if (phase_cnt + 9'h001 >= low_count) begin
               clk_low_phase <= 1'b0;
               clk_drive_low <= 1'b0;
               phase_cnt <= 9'h000;
            end else begin
               phase_cnt <= phase_cnt + 9'h001; // [R21]
            end
         end else if (scl_filtered || phase_cnt != 9'h000) begin
            // High phase counts only once the line has really risen (stretching)
            if (phase_cnt + 9'h001 >= high_count) begin
               clk_low_phase <= 1'b1;
               clk_drive_low <= 1'b1;
               phase_cnt <= 9'h000;
            end else begin
               phase_cnt <= phase_cnt + 9'h001;
            end
         end
      end
   end

   // Open-drain: output value fixed low, enable means pulling low
   assign serial_clock_pin_out = 1'b0; // [R22]
   assign serial_clock_pin_oe = interface_enable & clk_drive_low; // [R20] [R22]
   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe = interface_enable & data_drive_low; // [R22]

   // Interrupt gating and wakeup; same pipeline depth whether or not wake is set
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_irq <= 1'b0;
         match_irq <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         stop_irq <= stop_seen & stop_irq_enable & ~match_wakeup_bit; // [R8]
         match_irq <= match_seen; // [R7]
         wake_request <= match_seen & match_wakeup_bit & in_stop_mode; // [R4]
      end
   end
endmodule
`default_nettype wire

// >>> sbu_mode_ctrl_monitor.sv
// Assertion checker for the mode, line sense and clock width block
`timescale 1ns/1ps
`default_nettype none
`include "sbu_defines.vh"
module sbu_mode_ctrl_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic serial_clock_pin_out,
   input wire logic serial_data_pin_out,
   input wire logic serial_clock_pin_oe,
   input wire logic clock_drive_req,
   input wire logic stop_seen,
   input wire logic stop_irq_enable,
   input wire logic match_seen,
   input wire logic in_stop_mode,
   input wire logic stop_irq,
   input wire logic match_irq,
   input wire logic wake_request,
   input wire logic data_out_strobe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_match;
      match_seen ##1 match_irq;
   endsequence
   a_match_irq: assert property (match_seen |-> s_match)
      else $error("match irq missing");
   a_stop_cause: assert property (stop_irq |-> $past(stop_seen && stop_irq_enable))
      else $error("stop irq without cause");
   a_wake_cause: assert property (wake_request |-> $past(match_seen && in_stop_mode))
      else $error("wake without match in stop");
   a_clk_low_only: assert property (serial_clock_pin_out == 1'b0)
      else $error("clock pin drives high");
   a_dat_low_only: assert property (serial_data_pin_out == 1'b0)
      else $error("data pin drives high");
   a_mode_mapped: assert property (psel && penable && paddr == `SBU_ADDR_MODE |-> !pslverr)
      else $error("mode access refused");
   // The hold point must fall inside the low phase
   a_strobe_low: assert property (data_out_strobe |-> serial_clock_pin_oe)
      else $error("hold strobe outside low phase");
   a_low_start: assert property ($rose(serial_clock_pin_oe) |-> $past(clock_drive_req))
      else $error("low phase without request");
endmodule
`default_nettype wire

// >>> sbu_bus_model.sv
// Open-drain bus with pull-ups and an outside party that can pull either line
`timescale 1ns/1ps
`default_nettype none
module sbu_bus_model (
   input wire logic dut_scl_oe,
   input wire logic dut_sda_oe,
   input wire logic ext_scl_low,
   input wire logic ext_sda_low,
   output logic scl,
   output logic sda
);
   // Wired-AND: any party pulling wins, released lines float high
   assign scl = !(dut_scl_oe || ext_scl_low);
   assign sda = !(dut_sda_oe || ext_sda_low);
endmodule
`default_nettype wire

// >>> sbu_mode_ctrl_tb_top.sv
// Testbench for the mode, line sense and clock width block
`timescale 1ns/1ps
`default_nettype none
`include "sbu_defines.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module sbu_mode_ctrl_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr, sd;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic pready, pslverr, serial_clock_pin_in, serial_data_pin_in, ext_scl = 0, ext_sda = 0;
   logic serial_clock_pin_oe, serial_data_pin_oe, clock_drive_req = 0, data_drive_low = 0;
   logic stop_seen = 0, stop_irq_enable = 1, match_seen = 0, in_stop_mode = 0;
   logic stop_irq, match_irq, wake_request, fast_mode, data_out_strobe;
   logic scl_filtered, sda_filtered;
   int mismatches = 0, n_tests = 0, cyc = 0, n;
   sbu_mode_ctrl u_dut (.*, .serial_clock_pin_out(), .serial_data_pin_out());
   sbu_bus_model u_bus (.dut_scl_oe(serial_clock_pin_oe), .dut_sda_oe(serial_data_pin_oe),
      .ext_scl_low(ext_scl), .ext_sda_low(ext_sda), .scl(serial_clock_pin_in),
      .sda(serial_data_pin_in));
   initial forever #2.5 pclk = ~pclk;
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      serr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic pulse(input logic s);
      @(posedge pclk);
      stop_seen <= s;
      match_seen <= !s;
      @(posedge pclk);
      stop_seen <= 0;
      match_seen <= 0;
      @(negedge pclk);
   endtask
   task automatic t_regs;
      apb(0, `SBU_ADDR_MODE, 8'h00);
      `CHK(rdat, 32'h0)
      apb(0, `SBU_ADDR_LOW, 8'h00);
      `CHK(rdat, 32'hff)
      apb(0, `SBU_ADDR_HIGH, 8'h00);
      `CHK(rdat, 32'hff)
      apb(0, 12'h0f0, 8'h00);
      `CHK(serr, 1'b1)
      apb(1, `SBU_ADDR_MODE, 8'hff);
      apb(0, `SBU_ADDR_MODE, 8'h00);
      `CHK(rdat, 32'h8c)
      `CHK(fast_mode, 1'b1)
      apb(1, `SBU_ADDR_MODE, 8'h0c);
   endtask
   task automatic t_lines;
      apb(1, `SBU_ADDR_MAIN, 8'h80);
      data_drive_low <= 1;
      repeat (5) @(posedge pclk);
      apb(0, `SBU_ADDR_MODE, 8'h00);
      `CHK(rdat, 32'h2c)
      data_drive_low <= 0;
      ext_scl <= 1;
      repeat (6) @(posedge pclk);
      apb(0, `SBU_ADDR_MODE, 8'h00);
      `CHK(rdat, 32'h1c)
      `CHK(scl_filtered, 1'b0)
      repeat (3) @(posedge pclk);
      ext_scl <= 0;
      ext_sda <= 1;
      @(posedge pclk);
      ext_sda <= 0;
      repeat (8) @(negedge pclk) `CHK(sda_filtered, 1'b1)
      @(posedge pclk);
      apb(1, `SBU_ADDR_MAIN, 8'h00);
      apb(0, `SBU_ADDR_MODE, 8'h00);
      `CHK(rdat, 32'h0c)
   endtask
   task automatic t_irq;
      apb(1, `SBU_ADDR_MODE, 8'h80);
      repeat (3) @(posedge pclk);
      in_stop_mode <= 1;
      pulse(1);
      `CHK(stop_irq, 1'b0)
      pulse(0);
      `CHK({match_irq, wake_request}, 2'b11)
      @(posedge pclk);
      apb(1, `SBU_ADDR_MODE, 8'h08);
      pulse(0);
      `CHK({match_irq, wake_request}, 2'b10)
      pulse(1);
      `CHK(stop_irq, 1'b1)
      @(posedge pclk);
      in_stop_mode <= 0;
   endtask
   task automatic t_clock(input logic [7:0] m);
      apb(1, `SBU_ADDR_MODE, m);
      apb(1, `SBU_ADDR_LOW, 8'h08);
      apb(1, `SBU_ADDR_HIGH, 8'h04);
      apb(1, `SBU_ADDR_MAIN, 8'h80);
      clock_drive_req <= 1;
      n = 0;
      sd = 0;
      while (serial_clock_pin_oe !== 1'b1 && n < 300) @(negedge pclk) n++;
      n = 0;
      while (serial_clock_pin_oe === 1'b1 && n < 300) @(negedge pclk) begin
         sd = sd | data_out_strobe;
         n++;
      end
      `CHK(n, 8)
      `CHK(sd, 1'b1)
      @(posedge pclk);
      clock_drive_req <= 0;
      apb(1, `SBU_ADDR_MAIN, 8'h00);
   endtask
   task automatic test_done;
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Whole run is under two hundred cycles; the ceiling only catches a hang
   always @(posedge pclk) if (++cyc == 20000) begin
      mismatches++;
      test_done;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_regs;
      t_lines;
      t_irq;
      t_clock(8'h0c);
      t_clock(8'h08);
      test_done;
   end
endmodule
bind sbu_mode_ctrl sbu_mode_ctrl_monitor u_mon (.*);
`default_nettype wire
